// ==== logic/ssrp_defs.svh ====
/*
  Constants of the serial register port: target address, field positions,
  bit counts and line drive levels.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef SSRP_DEFS_SVH
`define SSRP_DEFS_SVH

// fixed upper six bits of the two-wire target address
`define SSRP_TGT_ADDR_HI 6'h2E
// auto-increment bit of the register pointer byte
`define SSRP_AUTOINC_BIT 7
// command byte fields, byte assembled most significant bit first
`define SSRP_SPI_RW_BIT 7
`define SSRP_SPI_MS_BIT 6
// index of the last bit of a byte
`define SSRP_BYTE_LAST 3'h7
// bit at which the first read pair is requested
`define SSRP_SPI_PAIR_REQ 3'h6
// active-low output enable levels
`define SSRP_OE_OFF 1'b1
`define SSRP_OE_ON 1'b0
// register bus reset values
`define SSRP_ADDR_RST 7'h00
`define SSRP_BYTE_RST 8'h00

`endif

// ==== logic/ssrp_pkg.sv ====
/*
  Types of the serial register port.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ssrp_pkg;

  typedef enum logic [3:0] {
    IDLE, ADDR, AACK, PTR, PACK, WRITE, WACK, READ, MACK
  } ssrp_i2c_state_t;

endpackage
`default_nettype wire

// ==== logic/ssrp_link_if.sv ====
/*
  Carrier between the system-clock core and the link-clock engine.
  Assumes toggles cross into the system-clock core through synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssrp_link_if;
  logic req_tog;
  logic [4:0] req_pair;
  logic [15:0] rd_pair;
  logic wr_tog;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic three_wire;
  logic dout;
  logic sdo_oe_n;
  logic sda_oe_n;

  modport link (
    output req_tog, req_pair, wr_tog, wr_addr, wr_data, dout, sdo_oe_n, sda_oe_n,
    input rd_pair, three_wire
  );
  modport core (
    input req_tog, req_pair, wr_tog, wr_addr, wr_data, dout, sdo_oe_n, sda_oe_n,
    output rd_pair, three_wire
  );
endinterface
`default_nettype wire

// ==== logic/ssrp_spi_link.sv ====
/*
  SPI engine on the serial port clock.
  Assumes the select pin resets it while high and the clock idles high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_defs.svh"
module ssrp_spi_link (
  input wire logic spc_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic rst_n_in,
  ssrp_link_if.link lk
);
  logic [6:0] sh_reg;
  logic [2:0] bcnt_reg;
  logic data_reg;
  logic rw_reg;
  logic ms_reg;
  logic [5:0] addr_reg;
  logic [7:0] tx_reg;
  logic [1:0] tw_reg;
  logic req_reg;
  logic [4:0] pair_reg;
  logic wr_reg;
  logic [5:0] wa_reg;
  logic [7:0] wd_reg;
  logic out_reg;
  logic sdo_oe_reg;
  logic sda_oe_reg;

  wire [7:0] byte_in = {sh_reg, sdi_in};
  wire last = bcnt_reg == `SSRP_BYTE_LAST;
  wire [5:0] addr_nx = addr_reg + {5'h00, ms_reg};
  wire [7:0] sel_byte = addr_reg[0] ? lk.rd_pair[7:0] : lk.rd_pair[15:8];
  wire drive = data_reg & rw_reg;
  wire cmd_req = ~data_reg & (bcnt_reg == `SSRP_SPI_PAIR_REQ) & sh_reg[5];
  wire blk_req = data_reg & rw_reg & (bcnt_reg == 3'h0);

  assign lk.req_tog = req_reg;
  assign lk.req_pair = pair_reg;
  assign lk.wr_tog = wr_reg;
  assign lk.wr_addr = wa_reg;
  assign lk.wr_data = wd_reg;
  assign lk.dout = out_reg;
  assign lk.sdo_oe_n = sdo_oe_reg;
  assign lk.sda_oe_n = sda_oe_reg;

  always_ff @(posedge spc_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tw_reg <= 2'h0;
    else
      tw_reg <= {tw_reg[0], lk.three_wire};
  end

  always_ff @(posedge spc_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      sh_reg <= 7'h00;
      bcnt_reg <= 3'h0;
      data_reg <= 1'b0;
      rw_reg <= 1'b0;
      ms_reg <= 1'b0;
      addr_reg <= 6'h00;
    end
    else
    begin
      sh_reg <= byte_in[6:0];
      bcnt_reg <= bcnt_reg + 3'h1;
      if (last && !data_reg)
      begin
        data_reg <= 1'b1;
        rw_reg <= byte_in[`SSRP_SPI_RW_BIT];
        ms_reg <= byte_in[`SSRP_SPI_MS_BIT];
        addr_reg <= byte_in[5:0];
      end
      else if (last)
        addr_reg <= addr_nx;
    end
  end

  // toggles and their payload survive the frame end
  always_ff @(posedge spc_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_reg <= 1'b0;
      pair_reg <= 5'h00;
      wr_reg <= 1'b0;
      wa_reg <= 6'h00;
      wd_reg <= `SSRP_BYTE_RST;
    end
    else if (!cs_n_in)
    begin
      // read pair fetched ahead of the block that needs it
      if (cmd_req || blk_req)
      begin
        req_reg <= ~req_reg;
        pair_reg <= cmd_req ? byte_in[4:0] : addr_nx[5:1];
      end
      // written byte handed to the core
      if (last && data_reg && !rw_reg)
      begin
        wr_reg <= ~wr_reg;
        wa_reg <= addr_reg;
        wd_reg <= byte_in;
      end
    end
  end

  // drive on falling edge from bit 8
  always_ff @(negedge spc_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      tx_reg <= `SSRP_BYTE_RST;
      out_reg <= 1'b0;
      sdo_oe_reg <= `SSRP_OE_OFF;
      sda_oe_reg <= `SSRP_OE_OFF;
    end
    else
    begin
      if (blk_req)
      begin
        out_reg <= sel_byte[7];
        tx_reg <= {sel_byte[6:0], 1'b0};
      end
      else
      begin
        out_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      // three-wire returns data on the input line
      sdo_oe_reg <= ~(drive & ~tw_reg[1]);
      sda_oe_reg <= ~(drive & tw_reg[1]);
    end
  end
endmodule
`default_nettype wire

// ==== logic/ssrp_top.sv ====
/*
  Serial register port: two-wire target and SPI slave in front of an
  8-bit register map.
  Assumes the map answers REG_RDATA_IN combinationally from REG_ADDR_OUT.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_defs.svh"
module ssrp_top (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic SPI_SELECT_N_IN,
  input wire logic SERIAL_CLOCK_IN,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_CLOCK_OE_N_OUT,
  input wire logic DATA_LINE_IN,
  output logic DATA_LINE_OUT,
  output logic DATA_LINE_OE_N_OUT,
  input wire logic ADDRESS_SELECT_PIN_IN,
  output logic SERIAL_DATA_OUT_OUT,
  output logic SERIAL_DATA_OUT_OE_N_OUT,
  input wire logic THREE_WIRE_SELECT_IN,
  output logic [6:0] REG_ADDR_OUT,
  output logic [7:0] REG_WDATA_OUT,
  output logic REG_WRITE_OUT,
  output logic REG_READ_OUT,
  input wire logic [7:0] REG_RDATA_IN,
  output logic BUS_BUSY_OUT
);
  logic [1:0] rst_reg;
  logic rst_n;
  logic [3:0] pin1_reg;
  logic [3:0] pin2_reg;
  logic [1:0] pin3_reg;
  ssrp_pkg::ssrp_i2c_state_t st_reg;
  ssrp_pkg::ssrp_i2c_state_t st_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [7:0] rx_reg;
  logic [7:0] rx_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [6:0] ptr_reg;
  logic [6:0] ptr_next;
  logic inc_reg;
  logic inc_next;
  logic rw_reg;
  logic rw_next;
  logic ackd_reg;
  logic ackd_next;
  logic oe_reg;
  logic oe_next;
  logic busy_reg;
  logic busy_next;
  logic i2c_rd;
  logic i2c_wr;
  logic lat_reg;
  logic stretch_reg;
  logic [2:0] req_s_reg;
  logic [2:0] wr_s_reg;
  logic [1:0] sv_reg;
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  logic tw_reg;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;
  logic [7:0] wdata_reg;
  logic rd_reg;
  logic wr_reg;

  ssrp_link_if lk ();

  ssrp_spi_link u_link (
    .spc_in(SERIAL_CLOCK_IN),
    .cs_n_in(SPI_SELECT_N_IN),
    .sdi_in(DATA_LINE_IN),
    .rst_n_in(rst_n),
    .lk(lk.link)
  );

  // pin order: clock, data, select, address-select
  wire [3:0] pins_in = {ADDRESS_SELECT_PIN_IN, SPI_SELECT_N_IN, DATA_LINE_IN,
                        SERIAL_CLOCK_IN};
  wire scl = pin2_reg[0];
  wire sda = pin2_reg[1];
  wire scl_d = pin3_reg[0];
  wire sda_d = pin3_reg[1];
  // select high picks the two-wire target
  wire i2c_en = pin2_reg[2];
  wire sa0 = pin2_reg[3];

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start = scl & scl_d & sda_d & ~sda;
  wire stop = scl & scl_d & ~sda_d & sda;

  // bytes arrive most significant bit first
  wire [7:0] byte_in = {rx_reg[6:0], sda};
  wire last = bit_reg == `SSRP_BYTE_LAST;
  // compare with fixed bits and pin level
  wire addr_hit = byte_in[7:1] == {`SSRP_TGT_ADDR_HI, sa0};
  wire [6:0] ptr_inc = ptr_reg + {6'h00, inc_reg};

  wire req_ev = req_s_reg[1] ^ req_s_reg[2];
  wire wr_ev = wr_s_reg[1] ^ wr_s_reg[2];
  wire spi_wr = ~i2c_en & wr_ev;
  wire spi_rd = ~i2c_en & ((req_ev & ~wr_ev) | (sv_reg == 2'h1));

  assign rst_n = rst_reg[1];
  assign lk.rd_pair = {hi_reg, lo_reg};
  assign lk.three_wire = tw_reg;
  assign REG_ADDR_OUT = addr_reg;
  assign REG_WDATA_OUT = wdata_reg;
  assign REG_WRITE_OUT = wr_reg;
  assign REG_READ_OUT = rd_reg;
  assign BUS_BUSY_OUT = busy_reg;
  assign SERIAL_CLOCK_OE_N_OUT = stretch_reg;
  assign DATA_LINE_OUT = lk.dout;
  assign SERIAL_DATA_OUT_OUT = lk.dout;
  assign SERIAL_DATA_OUT_OE_N_OUT = lk.sdo_oe_n;
  assign DATA_LINE_OE_N_OUT = oe_reg & lk.sda_oe_n;

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      rst_reg <= 2'h0;
    else
      rst_reg <= {rst_reg[0], 1'b1};
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin1_reg <= 4'hF;
      pin2_reg <= 4'hF;
      pin3_reg <= 2'h3;
      req_s_reg <= 3'h0;
      wr_s_reg <= 3'h0;
      tw_reg <= 1'b0;
      SERIAL_CLOCK_OUT <= 1'b0;
    end
    else
    begin
      pin1_reg <= pins_in;
      pin2_reg <= pin1_reg;
      pin3_reg <= pin2_reg[1:0];
      req_s_reg <= {req_s_reg[1:0], lk.req_tog};
      wr_s_reg <= {wr_s_reg[1:0], lk.wr_tog};
      tw_reg <= THREE_WIRE_SELECT_IN;
      SERIAL_CLOCK_OUT <= 1'b0;
    end
  end

  always_comb
  begin
    st_next = st_reg;
    bit_next = bit_reg;
    rx_next = rx_reg;
    tx_next = lat_reg ? REG_RDATA_IN : tx_reg;
    ptr_next = ptr_reg;
    inc_next = inc_reg;
    rw_next = rw_reg;
    ackd_next = ackd_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    i2c_rd = 1'b0;
    i2c_wr = 1'b0;
    if (!i2c_en)
    begin
      st_next = ssrp_pkg::IDLE;
      oe_next = `SSRP_OE_OFF;
      busy_next = 1'b0;
    end
    // start or repeated start from any state
    else if (start)
    begin
      st_next = ssrp_pkg::ADDR;
      bit_next = 3'h0;
      ackd_next = 1'b0;
      oe_next = `SSRP_OE_OFF;
      busy_next = 1'b1;
    end
    else if (stop)
    begin
      st_next = ssrp_pkg::IDLE;
      oe_next = `SSRP_OE_OFF;
      busy_next = 1'b0;
    end
    else
    begin
      unique case (st_reg)
        ssrp_pkg::IDLE:
          oe_next = `SSRP_OE_OFF;
        ssrp_pkg::ADDR, ssrp_pkg::PTR, ssrp_pkg::WRITE:
          if (scl_rise)
          begin
            rx_next = byte_in;
            bit_next = bit_reg + 3'h1;
            if (last && st_reg == ssrp_pkg::ADDR)
            begin
              rw_next = byte_in[0];
              // no match leaves data high, idles
              st_next = addr_hit ? ssrp_pkg::AACK : ssrp_pkg::IDLE;
            end
            // pointer byte sets register and increment
            else if (last && st_reg == ssrp_pkg::PTR)
            begin
              ptr_next = byte_in[6:0];
              inc_next = byte_in[`SSRP_AUTOINC_BIT];
              st_next = ssrp_pkg::PACK;
            end
            // each data byte written, pointer steps if auto-increment set
            else if (last)
            begin
              i2c_wr = 1'b1;
              ptr_next = ptr_inc;
              st_next = ssrp_pkg::WACK;
            end
          end
        ssrp_pkg::AACK:
          if (scl_fall && !ackd_reg)
          begin
            // hold data low through the acknowledge pulse
            oe_next = `SSRP_OE_ON;
            ackd_next = 1'b1;
            i2c_rd = rw_reg;
            ptr_next = rw_reg ? ptr_inc : ptr_reg;
          end
          else if (scl_fall)
          begin
            ackd_next = 1'b0;
            bit_next = 3'h0;
            st_next = rw_reg ? ssrp_pkg::READ : ssrp_pkg::PTR;
            oe_next = rw_reg ? tx_reg[7] : `SSRP_OE_OFF;
            tx_next = {tx_reg[6:0], 1'b0};
          end
        ssrp_pkg::PACK, ssrp_pkg::WACK:
          if (scl_fall)
          begin
            oe_next = ackd_reg ? `SSRP_OE_OFF : `SSRP_OE_ON;
            ackd_next = ~ackd_reg;
            bit_next = 3'h0;
            st_next = ackd_reg ? ssrp_pkg::WRITE : st_reg;
          end
        ssrp_pkg::READ:
        begin
          // first bit of a fetched byte once latched
          if (lat_reg)
          begin
            oe_next = REG_RDATA_IN[7];
            tx_next = {REG_RDATA_IN[6:0], 1'b0};
          end
          if (scl_fall)
          begin
            oe_next = tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
          if (scl_rise)
          begin
            bit_next = bit_reg + 3'h1;
            st_next = last ? ssrp_pkg::MACK : st_reg;
          end
        end
        ssrp_pkg::MACK:
        begin
          // acknowledged: fetch at the fall, clock already low
          if (scl_fall && ackd_reg)
          begin
            i2c_rd = 1'b1;
            ptr_next = ptr_inc;
            ackd_next = 1'b0;
            bit_next = 3'h0;
            st_next = ssrp_pkg::READ;
          end
          // transmitter releases data for the controller acknowledge
          else if (scl_fall)
            oe_next = `SSRP_OE_OFF;
          else if (scl_rise && !sda)
            ackd_next = 1'b1;
          else if (scl_rise)
            st_next = ssrp_pkg::IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= ssrp_pkg::IDLE;
      bit_reg <= 3'h0;
      rx_reg <= `SSRP_BYTE_RST;
      tx_reg <= `SSRP_BYTE_RST;
      ptr_reg <= `SSRP_ADDR_RST;
      inc_reg <= 1'b0;
      rw_reg <= 1'b0;
      ackd_reg <= 1'b0;
      oe_reg <= `SSRP_OE_OFF;
      busy_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      inc_reg <= inc_next;
      rw_reg <= rw_next;
      ackd_reg <= ackd_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
    end
  end

  // register bus address: two-wire pointer, SPI write address or SPI pair half
  always_comb
  begin
    addr_next = addr_reg;
    if (i2c_wr || i2c_rd)
      addr_next = ptr_reg;
    else if (spi_wr)
      addr_next = {1'b0, lk.wr_addr};
    else if (spi_rd)
      addr_next = {1'b0, lk.req_pair, sv_reg == 2'h1};
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg <= `SSRP_ADDR_RST;
      wdata_reg <= `SSRP_BYTE_RST;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      lat_reg <= 1'b0;
      stretch_reg <= `SSRP_OE_OFF;
    end
    else
    begin
      addr_reg <= addr_next;
      wdata_reg <= i2c_wr ? byte_in : (spi_wr ? lk.wr_data : wdata_reg);
      rd_reg <= i2c_rd | spi_rd;
      wr_reg <= i2c_wr | spi_wr;
      lat_reg <= i2c_rd;
      // hold the clock low while read data is fetched
      stretch_reg <= ~(i2c_rd | lat_reg);
    end
  end

  // SPI read pair: even register then odd register
  always_ff @(posedge SYS_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sv_reg <= 2'h0;
      hi_reg <= `SSRP_BYTE_RST;
      lo_reg <= `SSRP_BYTE_RST;
    end
    else
    begin
      if (spi_rd)
        sv_reg <= sv_reg + 2'h1;
      else if (sv_reg == 2'h2)
        sv_reg <= 2'h0;
      if (sv_reg == 2'h1)
        hi_reg <= REG_RDATA_IN;
      if (sv_reg == 2'h2)
        lo_reg <= REG_RDATA_IN;
    end
  end
endmodule
`default_nettype wire

// ==== dv/ssrp_props.sv ====
/*
  Checker on the pins of the serial register port.
  Assumes a bind onto ssrp_top; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrp_props (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic SPI_SELECT_N_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_CLOCK_OE_N_OUT,
  input wire logic DATA_LINE_IN,
  input wire logic DATA_LINE_OE_N_OUT,
  input wire logic SERIAL_DATA_OUT_OE_N_OUT,
  input wire logic THREE_WIRE_SELECT_IN,
  input wire logic [6:0] REG_ADDR_OUT,
  input wire logic REG_WRITE_OUT,
  input wire logic REG_READ_OUT,
  input wire logic BUS_BUSY_OUT
);
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  logic [3:0] sel_hist;
  logic i2c_hi;
  always_ff @(posedge SYS_CLK_IN)
    sel_hist <= {sel_hist[2:0], SPI_SELECT_N_IN};
  assign i2c_hi = (&sel_hist) & SPI_SELECT_N_IN & SERIAL_CLOCK_IN;
  a_busy_after_start: assert property (
    i2c_hi && $fell(DATA_LINE_IN) |-> ##[1:4] BUS_BUSY_OUT) else $error("busy not raised");
  a_idle_after_stop: assert property (
    i2c_hi && $rose(DATA_LINE_IN) |-> ##[1:4] !BUS_BUSY_OUT) else $error("busy not dropped");
  a_ack_held_high: assert property (
    i2c_hi && $past(SERIAL_CLOCK_IN) |-> $stable(DATA_LINE_OE_N_OUT))
    else $error("data drive moved while clock high");
  a_stretch_short: assert property (
    $fell(SERIAL_CLOCK_OE_N_OUT) |-> !$past(SERIAL_CLOCK_IN) ##[1:3] SERIAL_CLOCK_OE_N_OUT)
    else $error("clock stretch begun high or held too long");
  a_write_one_cycle: assert property (
    REG_WRITE_OUT |=> !REG_WRITE_OUT) else $error("write pulse too long");
  a_read_pair_order: assert property (
    !SPI_SELECT_N_IN && REG_READ_OUT && !$past(REG_READ_OUT) |-> !REG_ADDR_OUT[0] ##1
    (REG_READ_OUT && REG_ADDR_OUT[0] && REG_ADDR_OUT[6:1] == $past(REG_ADDR_OUT[6:1])))
    else $error("read pair out of order");
  a_spi_addr_six: assert property (
    !SPI_SELECT_N_IN && (REG_WRITE_OUT || REG_READ_OUT) |-> !REG_ADDR_OUT[6])
    else $error("spi address above six bits");
  a_sdo_only_spi: assert property (
    !SERIAL_DATA_OUT_OE_N_OUT |-> !SPI_SELECT_N_IN && !THREE_WIRE_SELECT_IN)
    else $error("data out driven outside four-wire frame");
  a_data_free_spi: assert property (
    !SPI_SELECT_N_IN && !THREE_WIRE_SELECT_IN |-> DATA_LINE_OE_N_OUT)
    else $error("data line driven in four-wire frame");
  c_two_wire_write: cover property (SPI_SELECT_N_IN && REG_WRITE_OUT);
  c_spi_read_pair: cover property (!SPI_SELECT_N_IN && REG_READ_OUT ##1 REG_READ_OUT);
  c_clock_stretch: cover property ($fell(SERIAL_CLOCK_OE_N_OUT));
endmodule
bind ssrp_top ssrp_props u_props (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN), .SPI_SELECT_N_IN(SPI_SELECT_N_IN),
  .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .SERIAL_CLOCK_OE_N_OUT(SERIAL_CLOCK_OE_N_OUT),
  .DATA_LINE_IN(DATA_LINE_IN), .DATA_LINE_OE_N_OUT(DATA_LINE_OE_N_OUT),
  .SERIAL_DATA_OUT_OE_N_OUT(SERIAL_DATA_OUT_OE_N_OUT),
  .THREE_WIRE_SELECT_IN(THREE_WIRE_SELECT_IN), .REG_ADDR_OUT(REG_ADDR_OUT),
  .REG_WRITE_OUT(REG_WRITE_OUT), .REG_READ_OUT(REG_READ_OUT), .BUS_BUSY_OUT(BUS_BUSY_OUT)
);
`default_nettype wire

// ==== dv/ssrp_host_model.sv ====
/*
  Host controller model: two-wire and SPI transfers on the shared pins.
  Assumes the bench resolves the open-drain and shared data wires.
*/
`timescale 1ns/1ps
`default_nettype none
module ssrp_host_model (
  input wire logic clk_line_in,
  input wire logic dat_line_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in,
  output logic clk_out,
  output logic dat_out,
  output logic sel_n_out
);
  logic [7:0] bufq [0:3];
  logic stall_err;
  initial
  begin
    clk_out = 1'b1;
    dat_out = 1'b1;
    sel_n_out = 1'b1;
    stall_err = 1'b0;
  end
  task automatic bit_x(input logic v, output logic s);
    int n;
    #200 dat_out = v;
    #200 clk_out = 1'b1;
    for (n = 0; n < 100 && clk_line_in !== 1'b1; n++) #20;
    if (n == 100) stall_err = 1'b1;
    #200 s = dat_line_in;
    #200 clk_out = 1'b0;
  endtask
  task automatic start_c();
    #200 dat_out = 1'b1;
    #200 clk_out = 1'b1;
    #400 dat_out = 1'b0;
    #400 clk_out = 1'b0;
  endtask
  task automatic stop_c();
    #200 dat_out = 1'b0;
    #200 clk_out = 1'b1;
    #400 dat_out = 1'b1;
    #400;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, s);
  endtask
  // change on fall, sample on rise
  task automatic spi_frame(input logic [7:0] cmd, input int nbits, input logic tw);
    logic [7:0] sh;
    sh = cmd;
    #3 sel_n_out = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++)
    begin
      clk_out = 1'b0;
      if (i > 7 && i % 8 == 0) sh = bufq[i / 8 - 1];
      dat_out = (tw && cmd[7] && i > 7) ? 1'b1 : sh[7];
      #80 clk_out = 1'b1;
      sh = {sh[6:0], tw ? dat_line_in : (sdo_oe_n_in ? 1'bx : sdo_in)};
      if (cmd[7] && i > 7 && i % 8 == 7) bufq[i / 8 - 1] = sh;
      #80;
    end
    dat_out = 1'b1;
    #160 sel_n_out = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire

// ==== dv/ssrp_top_test.sv ====
/*
  Self-checking bench of the serial register port with a register map.
  Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_defs.svh"
module ssrp_top_test;
  logic sys_clk, rst_n, asel, three_w, sel_n, clk_o, dat_o;
  logic scl_oe_n, scl_out, dl_out, dl_oe_n, serial_data_out, sdo_oe_n, reg_wr, reg_rd, busy;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] mem [0:127];
  logic [7:0] exp_mem [0:127];
  logic [31:0] seed;
  int fails, tests_run;
  wire clk_w = clk_o & (scl_oe_n | scl_out);
  wire dat_w = dl_oe_n ? dat_o : dl_out;
  ssrp_top uut (
    .SYS_CLK_IN(sys_clk), .RESET_N_IN(rst_n), .SPI_SELECT_N_IN(sel_n),
    .SERIAL_CLOCK_IN(clk_w), .SERIAL_CLOCK_OUT(scl_out), .SERIAL_CLOCK_OE_N_OUT(scl_oe_n),
    .DATA_LINE_IN(dat_w), .DATA_LINE_OUT(dl_out), .DATA_LINE_OE_N_OUT(dl_oe_n),
    .ADDRESS_SELECT_PIN_IN(asel), .SERIAL_DATA_OUT_OUT(serial_data_out),
    .SERIAL_DATA_OUT_OE_N_OUT(sdo_oe_n), .THREE_WIRE_SELECT_IN(three_w),
    .REG_ADDR_OUT(reg_addr), .REG_WDATA_OUT(reg_wdata), .REG_WRITE_OUT(reg_wr),
    .REG_READ_OUT(reg_rd), .REG_RDATA_IN(mem[reg_addr]), .BUS_BUSY_OUT(busy)
  );
  ssrp_host_model host (
    .clk_line_in(clk_w), .dat_line_in(dat_w), .sdo_in(serial_data_out), .sdo_oe_n_in(sdo_oe_n),
    .clk_out(clk_o), .dat_out(dat_o), .sel_n_out(sel_n)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (reg_wr === 1'b1) mem[reg_addr] <= reg_wdata;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // fixed upper bits, pin sets lsb
  function automatic logic [7:0] tgt(input logic sel, input logic rd);
    return {`SSRP_TGT_ADDR_HI, sel, rd};
  endfunction
  task automatic nxt(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want, input string what);
    tests_run++;
    if (seen !== want)
    begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic i2c_pair(input logic [7:0] ptr, input int nb);
    logic ack;
    logic [7:0] v;
    logic [6:0] p;
    @(negedge sys_clk);
    p = ptr[6:0];
    host.start_c();
    host.put_byte(tgt(asel, 1'b0), ack);
    chk({7'h00, ack}, 8'h01, "address ack");
    chk({7'h00, busy}, 8'h01, "busy after start");
    host.put_byte(ptr, ack);
    chk({7'h00, ack}, 8'h01, "pointer ack");
    for (int k = 0; k < nb; k++)
    begin
      nxt(v);
      host.put_byte(v, ack);
      chk({7'h00, ack}, 8'h01, "data ack");
      exp_mem[p] = v;
      p = ptr[7] ? p + 7'h01 : p;
    end
    host.stop_c();
    chk({7'h00, busy}, 8'h00, "busy after stop");
    p = ptr[6:0];
    host.start_c();
    host.put_byte(tgt(asel, 1'b0), ack);
    host.put_byte(ptr, ack);
    host.start_c();
    host.put_byte(tgt(asel, 1'b1), ack);
    chk({7'h00, ack}, 8'h01, "read address ack");
    for (int k = 0; k < nb; k++)
    begin
      host.get_byte(k == nb - 1, v);
      chk(v, exp_mem[p], "two-wire read byte");
      p = ptr[7] ? p + 7'h01 : p;
    end
    host.stop_c();
  endtask
  task automatic i2c_foreign();
    logic ack;
    @(negedge sys_clk);
    host.start_c();
    host.put_byte(tgt(~asel, 1'b0), ack);
    chk({7'h00, ack}, 8'h00, "foreign address ack");
    for (int k = 0; k < 2; k++)
    begin
      host.put_byte(k ? 8'hA5 : 8'h05, ack);
      chk({7'h00, ack}, 8'h00, "ignored byte ack");
    end
    host.stop_c();
  endtask
  task automatic spi_pair(input logic [5:0] ad, input logic inc, input int nb, input logic tw);
    logic [5:0] p;
    @(negedge sys_clk);
    p = ad;
    for (int k = 0; k < nb; k++)
    begin
      nxt(host.bufq[k]);
      exp_mem[{1'b0, p}] = host.bufq[k];
      p = inc ? p + 6'h01 : p;
    end
    host.spi_frame({1'b0, inc, ad}, 8 + 8 * nb, tw);
    host.spi_frame({1'b1, inc, ad}, 8 + 8 * nb, tw);
    p = ad;
    for (int k = 0; k < nb; k++)
    begin
      chk(host.bufq[k], exp_mem[{1'b0, p}], "spi read byte");
      p = inc ? p + 6'h01 : p;
    end
  endtask
  initial
  begin
    logic [7:0] v;
    fails = 0;
    tests_run = 0;
    seed = 32'h47A4AD8B;
    rst_n = 1'b0;
    asel = 1'b0;
    three_w = 1'b0;
    for (int i = 0; i < 128; i++)
    begin
      nxt(v);
      mem[i] = v;
      exp_mem[i] = v;
    end
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    for (int i = 0; i < 2; i++)
    begin
      asel = i[0];
      i2c_pair(8'h88, 3);
      i2c_foreign();
    end
    i2c_pair(8'h20, 2);
    spi_pair(6'h3E, 1'b1, 3, 1'b0);
    spi_pair(6'h3F, 1'b0, 2, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      nxt(v);
      spi_pair(v[5:0], v[6], 1 + v[7], 1'b0);
    end
    nxt(host.bufq[0]);
    nxt(host.bufq[1]);
    exp_mem[7'h12] = host.bufq[0];
    host.spi_frame(8'h52, 20, 1'b0);
    spi_pair(6'h12, 1'b0, 1, 1'b0);
    three_w = 1'b1;
    repeat (4) @(negedge sys_clk);
    spi_pair(6'h3E, 1'b1, 2, 1'b1);
    three_w = 1'b0;
    for (int i = 0; i < 128; i++) chk(mem[i], exp_mem[i], "map contents");
    chk({7'h00, host.stall_err}, 8'h00, "clock stall");
    complete_run();
  end
endmodule
`default_nettype wire
